//--- rtl/shu_consts.svh
`ifndef SHU_CONSTS_SVH
`define SHU_CONSTS_SVH
// ==========================================
// Control space layout
`define SHU_CS_BYTES 20
`define SHU_OFF_OBUF 5'h00
`define SHU_OFF_IBUF 5'h02
`define SHU_OFF_RATE 5'h04
`define SHU_OFF_FMT 5'h06
`define SHU_OFF_STOP 5'h08
`define SHU_OFF_TERM 5'h0a
`define SHU_OFF_MODE 5'h0c
`define SHU_OFF_XCHR 5'h0e
`define SHU_OFF_TOUT 5'h10
`define SHU_OFF_XLAT 5'h12
// ==========================================
// Defaults loaded at reset
`define SHU_RST_OBUF 16'h2000
`define SHU_RST_IBUF 16'h2000
`define SHU_RST_RATE 16'h2580
`define SHU_RST_FMT 16'h0207
`define SHU_RST_STOP 16'h0000
`define SHU_RST_TERM 16'h0104
`define SHU_RST_MODE 16'h0000
`define SHU_RST_XCHR 16'h1311
`define SHU_RST_TOUT 16'h0000
`define SHU_RST_XLAT 16'h0001
// ==========================================
// Commands, limits, timing
`define SHU_CMD_INIT 16'h0006
`define SHU_RATE_MIN 16'h006e
`define SHU_RATE_MAX 16'h4b00
`define SHU_CLK_HZ 20000000
`define SHU_SYNC_STAGES 2
`endif

//--- rtl/shu_pkg.sv
package shu_pkg;
  typedef enum logic [1:0] {
    SHU_MODE_TERM = 2'b00,
    SHU_MODE_MODEM = 2'b01,
    SHU_MODE_IGNORE = 2'b10,
    SHU_MODE_SET = 2'b11
  } shu_mode_e;
  typedef enum logic [1:0] {
    SHU_PAR_NONE = 2'b00,
    SHU_PAR_ODD = 2'b01,
    SHU_PAR_EVEN = 2'b10
  } shu_par_e;
  typedef struct packed {
    logic [16:0] half_div;
    logic bits8;
    shu_par_e parity;
    logic [1:0] stop;
    logic echo;
    shu_mode_e mode;
    logic xon_en;
    logic [7:0] xon_chr;
    logic [7:0] xoff_chr;
  } shu_cfg_s;
  typedef struct packed {
    logic txd;
    logic rts;
    logic dtr;
  } shu_line_out_s;
  typedef struct packed {
    logic rxd;
    logic cts;
    logic dsr;
    logic dcd;
  } shu_line_in_s;
endpackage

//--- rtl/shu_uart.sv
`timescale 1ns/1ps
`default_nettype none
`include "shu_consts.svh"
// Notes on behaviour
// [RULE1] Terminal: raise RTS, send only while CTS
// [RULE2] Terminal receive: RTS off while ready
// [RULE3] Modem: transmit only while DSR on
// [RULE4] Modem receive: device CTS, then our RTS
// [RULE5] Modem: RTS off when input full
// [RULE6] Start, data LSB first, parity, stops
// [RULE7] Parity counts information bits only
// [RULE8] No parity: none sent, none checked
// [RULE9] Command 0x0006 applies parameters, initializes
// [RULE10] 16-bit words, bytes swapped locally
// [RULE11] Buffer sizes 0..65535, default 8192
// [RULE12] Rate in bps, 110 to 19200
// [RULE13] Format low byte: 7 or 8 bits
// [RULE14] Format high byte: none, odd, even
// [RULE15] Stop code: one, one-half, two
// [RULE16] Echo retransmits received characters
// [RULE17] Host transfers at least 20 bytes
// [RULE18] Reset loads every documented default
// [RULE19] Turnaround: RTS drop answered by CTS
// [RULE20] XOFF stops transmit until XON
// [RULE21] Mode byte: terminal, modem, ignore, set
// [RULE22] Ignore: DTR, RTS always on
// [RULE23] Bit period from rate, centre sampling
// [RULE24] Received parity mismatch flags error
module shu_uart #(
  parameter int CLK_HZ = `SHU_CLK_HZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cs_we,
  input wire logic cs_re,
  input wire logic [4:0] cs_addr,
  input wire logic [15:0] cs_wdata,
  output logic [15:0] cs_rdata,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_parity_err,
  output logic rx_frame_err,
  input wire logic rx_ready,
  input wire shu_pkg::shu_line_in_s line_in,
  output shu_pkg::shu_line_out_s line_out
);
  import shu_pkg::*;

  typedef enum logic [2:0] {
    SHU_B_IDLE = 3'b000,
    SHU_B_START = 3'b001,
    SHU_B_DATA = 3'b010,
    SHU_B_PAR = 3'b011,
    SHU_B_STOP = 3'b100
  } shu_bit_e;

  if (CLK_HZ < 2 * 19200 * 4 || CLK_HZ / (2 * 110) > 131071) begin : g_clk_check
    $error("shu_uart: clock outside the range the bit timer can serve");
  end

  // ==========================================
  // Control space, bytes held low first
  logic [7:0] cs_mem_ff [`SHU_CS_BYTES];
  localparam logic [15:0] CS_DEFAULTS [`SHU_CS_BYTES/2] = '{
    `SHU_RST_OBUF, `SHU_RST_IBUF, `SHU_RST_RATE, `SHU_RST_FMT, `SHU_RST_STOP,
    `SHU_RST_TERM, `SHU_RST_MODE, `SHU_RST_XCHR, `SHU_RST_TOUT, `SHU_RST_XLAT};

  function automatic logic [15:0] cs_word(input logic [4:0] off);
    logic [4:0] a;
    a = {off[4:1], 1'b0};
    cs_word = {cs_mem_ff[a + 5'd1], cs_mem_ff[a]}; // [RULE10]
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SHU_CS_BYTES / 2; i++) begin
        cs_mem_ff[2*i] <= CS_DEFAULTS[i][7:0]; // [RULE18] [RULE11]
        cs_mem_ff[2*i+1] <= CS_DEFAULTS[i][15:8];
      end
    end else if (cs_we && cs_addr < 5'(`SHU_CS_BYTES)) begin
      cs_mem_ff[{cs_addr[4:1], 1'b0}] <= cs_wdata[7:0]; // [RULE10]
      cs_mem_ff[{cs_addr[4:1], 1'b1}] <= cs_wdata[15:8];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_rdata <= 16'h0000;
    end else if (cs_re) begin
      cs_rdata <= (cs_addr < 5'(`SHU_CS_BYTES)) ? cs_word(cs_addr) : 16'h0000;
    end
  end

  // ==========================================
  // Active configuration, applied on init command
  function automatic shu_cfg_s decode_cfg(input logic [15:0] rate, input logic [15:0] fmt,
                                          input logic [15:0] stp, input logic [15:0] md,
                                          input logic [15:0] xc);
    shu_cfg_s c;
    logic [15:0] r;
    r = (rate < `SHU_RATE_MIN) ? `SHU_RATE_MIN : (rate > `SHU_RATE_MAX) ? `SHU_RATE_MAX : rate; // [RULE12]
    c.half_div = 17'(CLK_HZ / (2 * int'(r))); // [RULE23]
    c.bits8 = (fmt[7:0] == 8'h08); // [RULE13]
    c.parity = (fmt[15:8] == 8'h01) ? SHU_PAR_ODD :
               (fmt[15:8] == 8'h02) ? SHU_PAR_EVEN : SHU_PAR_NONE; // [RULE14]
    c.stop = (stp[7:0] > 8'h02) ? 2'b00 : stp[1:0]; // [RULE15]
    c.echo = (stp[15:8] == 8'h01); // [RULE16]
    c.mode = shu_mode_e'(md[1:0]); // [RULE21]
    c.xon_en = (md[15:8] == 8'h01);
    c.xon_chr = xc[7:0];
    c.xoff_chr = xc[15:8];
    decode_cfg = c;
  endfunction

  localparam shu_cfg_s CFG_RST = decode_cfg(`SHU_RST_RATE, `SHU_RST_FMT, `SHU_RST_STOP,
                                            `SHU_RST_MODE, `SHU_RST_XCHR);
  shu_cfg_s cfg_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= CFG_RST; // [RULE18]
    end else if (cmd_valid && cmd_code == `SHU_CMD_INIT) begin
      cfg_ff <= decode_cfg(cs_word(`SHU_OFF_RATE), cs_word(`SHU_OFF_FMT), cs_word(`SHU_OFF_STOP),
                           cs_word(`SHU_OFF_MODE), cs_word(`SHU_OFF_XCHR)); // [RULE9]
    end
  end
  wire logic init_cmd = cmd_valid && cmd_code == `SHU_CMD_INIT;

  // ==========================================
  // Pin synchronisers
  shu_line_in_s sync1_ff, sync2_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= '{rxd: 1'b1, default: 1'b0};
      sync2_ff <= '{rxd: 1'b1, default: 1'b0};
    end else begin
      sync1_ff <= line_in;
      sync2_ff <= sync1_ff;
    end
  end

  // ==========================================
  // Handshake gates
  shu_bit_e tx_st_ff, rx_st_ff;
  logic echo_pend_ff, xoff_hold_ff;
  logic tx_gate, rx_gate, tx_want;
  assign tx_want = tx_valid || echo_pend_ff || tx_st_ff != SHU_B_IDLE;
  always_comb begin
    unique case (cfg_ff.mode)
      SHU_MODE_TERM: begin
        tx_gate = sync2_ff.cts; // [RULE1]
        rx_gate = sync2_ff.dsr && sync2_ff.dcd;
      end
      SHU_MODE_MODEM: begin
        tx_gate = sync2_ff.dsr; // [RULE3]
        rx_gate = sync2_ff.cts && line_out.rts; // [RULE4]
      end
      SHU_MODE_IGNORE: begin
        tx_gate = 1'b1; // [RULE22]
        rx_gate = 1'b1;
      end
      SHU_MODE_SET: begin
        tx_gate = sync2_ff.cts;
        rx_gate = sync2_ff.dcd;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_out.rts <= 1'b0;
      line_out.dtr <= 1'b0;
    end else begin
      unique case (cfg_ff.mode)
        SHU_MODE_TERM: begin
          line_out.rts <= tx_want ? 1'b1 : !rx_ready; // [RULE1] [RULE2] [RULE19]
          line_out.dtr <= 1'b1;
        end
        SHU_MODE_MODEM: begin
          line_out.rts <= sync2_ff.cts && rx_ready; // [RULE4] [RULE5] [RULE19]
          line_out.dtr <= rx_ready;
        end
        default: begin
          line_out.rts <= 1'b1; // [RULE22]
          line_out.dtr <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================
  // Bit lengths
  logic [19:0] bit_len, half_len, stop_len;
  assign half_len = {3'b000, cfg_ff.half_div};
  assign bit_len = {2'b00, cfg_ff.half_div, 1'b0}; // [RULE23]
  assign stop_len = bit_len + ((cfg_ff.stop == 2'b01) ? half_len :
                    (cfg_ff.stop == 2'b10) ? bit_len : 20'h00000); // [RULE15]

  function automatic logic par_bit(input logic [7:0] d, input logic b8, input shu_par_e p);
    logic ones;
    ones = b8 ? ^d : ^d[6:0]; // [RULE7]
    par_bit = (p == SHU_PAR_ODD) ? !ones : ones;
  endfunction

  // ==========================================
  // Transmitter
  logic [19:0] tx_tmr_ff;
  logic [7:0] tx_sh_ff;
  logic [2:0] tx_cnt_ff;
  logic tx_par_ff;
  logic tx_start;
  assign tx_ready = tx_st_ff == SHU_B_IDLE && tx_gate && !echo_pend_ff && !xoff_hold_ff;
  assign tx_start = tx_st_ff == SHU_B_IDLE && tx_gate && !xoff_hold_ff &&
                    (echo_pend_ff || tx_valid); // [RULE1] [RULE20]
  logic [7:0] echo_chr_ff;
  wire logic [7:0] tx_src = echo_pend_ff ? echo_chr_ff : tx_data; // [RULE16]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_ff <= SHU_B_IDLE;
      tx_tmr_ff <= 20'h00000;
      tx_sh_ff <= 8'h00;
      tx_cnt_ff <= 3'h0;
      tx_par_ff <= 1'b0;
      line_out.txd <= 1'b1;
    end else if (init_cmd) begin
      tx_st_ff <= SHU_B_IDLE;
      line_out.txd <= 1'b1;
    end else if (tx_st_ff == SHU_B_IDLE) begin
      if (tx_start) begin
        tx_st_ff <= SHU_B_START;
        tx_tmr_ff <= bit_len - 20'h00001;
        tx_sh_ff <= tx_src;
        tx_par_ff <= par_bit(tx_src, cfg_ff.bits8, cfg_ff.parity);
        line_out.txd <= 1'b0; // [RULE6]
      end
    end else if (tx_tmr_ff != 20'h00000) begin
      tx_tmr_ff <= tx_tmr_ff - 20'h00001;
    end else begin
      unique case (tx_st_ff)
        SHU_B_START, SHU_B_DATA: begin
          if (tx_st_ff == SHU_B_DATA && tx_cnt_ff == (cfg_ff.bits8 ? 3'h7 : 3'h6)) begin
            tx_st_ff <= (cfg_ff.parity == SHU_PAR_NONE) ? SHU_B_STOP : SHU_B_PAR; // [RULE8]
            line_out.txd <= (cfg_ff.parity == SHU_PAR_NONE) ? 1'b1 : tx_par_ff;
            tx_tmr_ff <= ((cfg_ff.parity == SHU_PAR_NONE) ? stop_len : bit_len) - 20'h00001;
          end else begin
            tx_cnt_ff <= (tx_st_ff == SHU_B_START) ? 3'h0 : tx_cnt_ff + 3'h1;
            tx_st_ff <= SHU_B_DATA;
            line_out.txd <= tx_sh_ff[0]; // [RULE6]
            tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
            tx_tmr_ff <= bit_len - 20'h00001;
          end
        end
        SHU_B_PAR: begin
          tx_st_ff <= SHU_B_STOP;
          line_out.txd <= 1'b1;
          tx_tmr_ff <= stop_len - 20'h00001;
        end
        SHU_B_STOP: tx_st_ff <= SHU_B_IDLE;
        default: tx_st_ff <= SHU_B_IDLE;
      endcase
    end
  end

  // ==========================================
  // Receiver, samples at bit centre
  logic [19:0] rx_tmr_ff;
  logic [7:0] rx_sh_ff;
  logic [2:0] rx_cnt_ff;
  logic rx_par_ff, rx_done;
  logic [7:0] rx_chr;
  assign rx_chr = cfg_ff.bits8 ? rx_sh_ff : {1'b0, rx_sh_ff[7:1]};
  assign rx_done = rx_st_ff == SHU_B_STOP && rx_tmr_ff == 20'h00000;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_ff <= SHU_B_IDLE;
      rx_tmr_ff <= 20'h00000;
      rx_sh_ff <= 8'h00;
      rx_cnt_ff <= 3'h0;
      rx_par_ff <= 1'b0;
    end else if (init_cmd) begin
      rx_st_ff <= SHU_B_IDLE;
    end else if (rx_st_ff == SHU_B_IDLE) begin
      if (rx_gate && !sync2_ff.rxd) begin
        rx_st_ff <= SHU_B_START;
        rx_tmr_ff <= half_len - 20'h00001; // [RULE23]
      end
    end else if (rx_tmr_ff != 20'h00000) begin
      rx_tmr_ff <= rx_tmr_ff - 20'h00001;
    end else begin
      rx_tmr_ff <= bit_len - 20'h00001;
      unique case (rx_st_ff)
        SHU_B_START: begin
          rx_st_ff <= sync2_ff.rxd ? SHU_B_IDLE : SHU_B_DATA;
          rx_cnt_ff <= 3'h0;
        end
        SHU_B_DATA: begin
          rx_sh_ff <= {sync2_ff.rxd, rx_sh_ff[7:1]}; // [RULE6]
          rx_cnt_ff <= rx_cnt_ff + 3'h1;
          if (rx_cnt_ff == (cfg_ff.bits8 ? 3'h7 : 3'h6)) begin
            rx_st_ff <= (cfg_ff.parity == SHU_PAR_NONE) ? SHU_B_STOP : SHU_B_PAR; // [RULE8]
          end
        end
        SHU_B_PAR: begin
          rx_par_ff <= sync2_ff.rxd;
          rx_st_ff <= SHU_B_STOP;
        end
        SHU_B_STOP: rx_st_ff <= SHU_B_IDLE;
        default: rx_st_ff <= SHU_B_IDLE;
      endcase
    end
  end

  // ==========================================
  // Delivery, software flow control, echo
  logic is_flow;
  assign is_flow = cfg_ff.xon_en && (rx_chr == cfg_ff.xoff_chr || rx_chr == cfg_ff.xon_chr);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_parity_err <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_valid <= rx_done && !is_flow;
      if (rx_done && !is_flow) begin
        rx_data <= rx_chr;
        rx_parity_err <= cfg_ff.parity != SHU_PAR_NONE &&
                         rx_par_ff != par_bit(rx_chr, cfg_ff.bits8, cfg_ff.parity); // [RULE24]
        rx_frame_err <= !sync2_ff.rxd;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      xoff_hold_ff <= 1'b0;
    end else if (init_cmd || !cfg_ff.xon_en) begin
      xoff_hold_ff <= 1'b0;
    end else if (rx_done && rx_chr == cfg_ff.xoff_chr) begin
      xoff_hold_ff <= 1'b1; // [RULE20]
    end else if (rx_done && rx_chr == cfg_ff.xon_chr) begin
      xoff_hold_ff <= 1'b0; // [RULE20]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      echo_pend_ff <= 1'b0;
      echo_chr_ff <= 8'h00;
    end else if (rx_done && !is_flow && cfg_ff.echo) begin
      echo_pend_ff <= 1'b1; // [RULE16]
      echo_chr_ff <= rx_chr;
    end else if (tx_start || init_cmd) begin
      echo_pend_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verification/shu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Port checker
module shu_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cs_we,
  input wire logic cs_re,
  input wire logic [4:0] cs_addr,
  input wire logic [15:0] cs_wdata,
  input wire logic [15:0] cs_rdata,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire shu_pkg::shu_line_in_s line_in,
  input wire shu_pkg::shu_line_out_s line_out
);
  import shu_pkg::*;
  logic [1:0] wmode_ff;
  logic [1:0] mode_ff;
  logic trm;
  logic mdm;
  logic ign;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ====
  // Mode tracking
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) wmode_ff <= 2'h0;
    else if (cs_we && cs_addr[4:1] == 4'h6) wmode_ff <= cs_wdata[1:0];
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) mode_ff <= 2'h0;
    else if (cmd_valid && cmd_code == 16'h0006) mode_ff <= wmode_ff;
  end
  assign trm = mode_ff == SHU_MODE_TERM || mode_ff == SHU_MODE_SET;
  assign mdm = mode_ff == SHU_MODE_MODEM;
  assign ign = mode_ff == SHU_MODE_IGNORE;
  // ====
  // Properties
  a_take_starts: assert property (tx_valid && tx_ready |=> !line_out.txd)
    else $error("txd did not start on take");
  a_start_holds: assert property ($fell(line_out.txd) |-> !line_out.txd [*8])
    else $error("start bit too short");
  a_busy_refuse: assert property (!line_out.txd |-> !tx_ready)
    else $error("ready within frame");
  a_unmapped_zero: assert property (cs_re && cs_addr >= 5'h14 |=> cs_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rx_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("rx_valid longer than one cycle");
  a_rx_hold: assert property (!rx_valid |-> $stable(rx_data))
    else $error("rx_data moved without rx_valid");
  a_term_cts: assert property ((trm && !line_in.cts) [*5] |-> !tx_ready)
    else $error("sent without cts");
  a_modem_dsr: assert property ((mdm && !line_in.dsr) [*5] |-> !tx_ready)
    else $error("sent without dsr");
  a_modem_req: assert property ((mdm && !line_in.cts) [*5] |-> !line_out.rts)
    else $error("rts before device request");
  a_modem_full: assert property ((mdm && !rx_ready) [*5] |-> !line_out.rts)
    else $error("rts while input full");
  a_ignore_on: assert property (ign [*5] |-> line_out.rts && line_out.dtr)
    else $error("ignore lines not on");
  c_take: cover property (tx_valid && tx_ready);
  c_rx: cover property (rx_valid);
  c_mdm_rts: cover property (mdm && line_out.rts);
endmodule
bind shu_uart shu_monitor i_shu_monitor (.core_clk(core_clk), .rst_n(rst_n), .cs_we(cs_we),
  .cs_re(cs_re), .cs_addr(cs_addr), .cs_wdata(cs_wdata), .cs_rdata(cs_rdata),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .line_in(line_in),
  .line_out(line_out));
`default_nettype wire

//--- verification/shu_term_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Serial terminal model
module shu_term_model (
  input wire logic core_clk,
  input wire shu_pkg::shu_line_out_s line_out,
  input wire logic [2:0] ctl,
  output var shu_pkg::shu_line_in_s line_in
);
  import shu_pkg::*;
  localparam int BT = 2 * (20000000 / 38400);
  logic rxd_q = 1'b1;
  assign line_in = {rxd_q, ctl};
  task automatic send(input logic [15:0] f, input int n);
    for (int b = 0; b < n; b++) begin
      rxd_q = f[b];
      repeat (BT) @(posedge core_clk);
      #1;
    end
    rxd_q = 1'b1;
  endtask
  task automatic catch(input int n, output logic [15:0] f, output int w);
    f = 16'hffff;
    for (w = 0; w < 40000 && line_out.txd !== 1'b0; w++) begin
      @(posedge core_clk);
      #1;
    end
    repeat (BT / 2) @(posedge core_clk);
    #1;
    for (int b = 0; b < n; b++) begin
      if (b > 0) begin
        repeat (BT) @(posedge core_clk);
        #1;
      end
      f[b] = line_out.txd;
    end
  endtask
endmodule
`default_nettype wire

//--- verification/tb_serial_port_handshake_uart.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_handshake_uart;
  import shu_pkg::*;
  localparam int BT = 2 * (20000000 / 38400);
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_we = 1'b0;
  logic cs_re = 1'b0;
  logic cmd_valid = 1'b0;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b1;
  logic [4:0] cs_addr = 5'h00;
  logic [15:0] cs_wdata = 16'h0000;
  logic [15:0] cmd_code = 16'h0000;
  logic [7:0] tx_data = 8'h00;
  logic [2:0] ctl = 3'h7;
  logic [15:0] cs_rdata, f, v;
  logic [7:0] rx_data;
  logic tx_ready, rx_valid, rx_parity_err, rx_frame_err;
  shu_line_in_s line_in;
  shu_line_out_s line_out;
  int error_cnt = 0;
  int cmp_count = 0;
  int w;
  logic [4:0] ao [7] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h14};
  logic [15:0] ev [7] = '{16'h2000, 16'h2000, 16'h2580, 16'h0207, 16'h0, 16'h0, 16'h0};
  logic [15:0] ft [3] = '{16'h0207, 16'h0108, 16'h0008};
  logic [15:0] st [3] = '{16'h0000, 16'h0000, 16'h0002};
  logic [7:0] dt [3] = '{8'h41, 8'ha5, 8'h3c};
  shu_uart i_shu_uart (.core_clk(core_clk), .rst_n(rst_n), .cs_we(cs_we), .cs_re(cs_re),
    .cs_addr(cs_addr), .cs_wdata(cs_wdata), .cs_rdata(cs_rdata), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_parity_err(rx_parity_err),
    .rx_frame_err(rx_frame_err), .rx_ready(rx_ready), .line_in(line_in), .line_out(line_out));
  shu_term_model u_term (.core_clk(core_clk), .line_out(line_out), .ctl(ctl), .line_in(line_in));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // ====
  // Helpers
  task automatic end_of_test();
    $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bound(input int i, input int lim);
    if (i >= lim) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    cs_addr = a;
    cs_wdata = d;
    cs_we = 1'b1;
    tick(1);
    cs_we = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    cs_addr = a;
    cs_re = 1'b1;
    tick(1);
    cs_re = 1'b0;
    d = cs_rdata;
    tick(1);
  endtask
  task automatic cfg(input logic [15:0] fm, input logic [15:0] sw, input logic [15:0] md);
    wr(5'h06, fm);
    wr(5'h08, sw);
    wr(5'h0c, md);
    wr(5'h04, 16'h4b00);
    cmd_code = 16'h0006;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    tick(10);
  endtask
  task automatic send_tx(input logic [7:0] d);
    int i;
    tx_data = d;
    tx_valid = 1'b1;
    for (i = 0; i < 30000 && tx_ready !== 1'b1; i++) tick(1);
    bound(i, 30000);
    tick(1);
    tx_valid = 1'b0;
  endtask
  task automatic wait_rx(input logic [7:0] d, input logic pe);
    int i;
    for (i = 0; i < 15000 && rx_valid !== 1'b1; i++) tick(1);
    bound(i, 15000);
    check("rx_word", {rx_parity_err, rx_frame_err, rx_data}, {pe, 1'b0, d});
  endtask
  function automatic int flen(input logic [15:0] fm, input logic [15:0] sw);
    return ((fm[7:0] == 8'h08) ? 9 : 8) + (fm[9:8] != 2'h0) + ((sw[1:0] == 2'h2) ? 2 : 1);
  endfunction
  function automatic logic [15:0] frame(input logic [7:0] d, input logic [15:0] fm);
    logic [15:0] r;
    int nb;
    nb = (fm[7:0] == 8'h08) ? 8 : 7;
    r = 16'hffff;
    r[0] = 1'b0;
    for (int i = 0; i < nb; i++) r[i + 1] = d[i];
    if (fm[9:8] != 2'h0) r[nb + 1] = ^d[6:0] ^ (nb == 8 && d[7]) ^ (fm[9:8] == 2'h1);
    return r;
  endfunction
  // ====
  // Sequence
  initial begin
    tick(20);
    rst_n = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(ao[i], v);
      check("cs_word", v, ev[i]);
    end
    wr(5'h14, 16'hbeef);
    rd(5'h14, v);
    check("unmapped", v, 16'h0000);
    wr(5'h00, 16'hff12);
    rd(5'h00, v);
    check("obuf", v, 16'hff12);
    for (int k = 0; k < 3; k++) begin
      cfg(ft[k], st[k], 16'h0000);
      if (k == 0) begin
        ctl = 3'h3;
        tick(3);
        tx_data = dt[0];
        tx_valid = 1'b1;
        tick(100);
        check("tx_gate", {tx_ready, line_out.txd, line_out.rts}, 3'b011);
        ctl = 3'h7;
      end
      fork
        send_tx(dt[k]);
        u_term.catch(flen(ft[k], st[k]), f, w);
      join
      #1;
      bound(w, 40000);
      check("tx_frame", f, frame(dt[k], ft[k]));
      check("stop_len", tx_ready, 1'b0);
      for (w = 0; w < BT && tx_ready !== 1'b1; w++) tick(1);
      bound(w, BT);
    end
    cfg(16'h0207, 16'h0000, 16'h0000);
    check("rts_ready", line_out.rts, 1'b0);
    rx_ready = 1'b0;
    tick(5);
    check("rts_full", line_out.rts, 1'b1);
    rx_ready = 1'b1;
    for (int k = 0; k < 3; k++) begin
      if (k == 2) cfg(16'h0207, 16'h0100, 16'h0000);
      f = frame(8'h41, 16'h0207) ^ ((k == 1) ? 16'h0100 : 16'h0000);
      fork
        u_term.send(f, 10);
        wait_rx(8'h41, k == 1);
        if (k == 2) u_term.catch(10, v, w);
      join
    end
    check("echo", v, frame(8'h41, 16'h0207));
    ctl = 3'h1;
    cfg(16'h0207, 16'h0000, 16'h0001);
    tx_data = 8'h5a;
    tx_valid = 1'b1;
    tick(100);
    check("mdm_hold", {line_out.txd, line_out.rts, line_out.dtr}, 3'b101);
    tx_valid = 1'b0;
    ctl = 3'h5;
    tick(10);
    check("mdm_req", line_out.rts, 1'b1);
    rx_ready = 1'b0;
    tick(5);
    check("mdm_full", {line_out.rts, line_out.dtr}, 2'b00);
    rx_ready = 1'b1;
    ctl = 3'h3;
    tick(10);
    check("turn", line_out.rts, 1'b0);
    fork
      send_tx(8'h5a);
      u_term.catch(10, f, w);
    join
    #1;
    check("mdm_frame", f, frame(8'h5a, 16'h0207));
    ctl = 3'h0;
    rx_ready = 1'b0;
    for (int m = 2; m < 4; m++) begin
      cfg(16'h0207, 16'h0000, 16'(m));
      check("ign_lines", {line_out.rts, line_out.dtr}, 2'b11);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
